/* File: hdl/alias_decode.sv */
// Alias address decoder: region classification and target computation.
// Assumes a combinational use inside the remapper.
`timescale 1ns/100ps
`include "bitband_defines.svh"

module alias_decode (
    input wire logic [31:0] addr_i,
    input wire logic fetch_i,
    output bitband_pkg::region_t region_o,
    output logic fetch_fault_o,
    output logic [31:0] target_o,
    output logic [2:0] bit_o
);
    import bitband_pkg::*;

    logic in_sram;
    logic in_peri;
    logic [31:0] base;
    logic [31:0] offs;

    assign in_sram = (addr_i >= `SRAM_ALIAS_BASE) && (addr_i <= `SRAM_ALIAS_LAST);
    assign in_peri = (addr_i >= `PERI_ALIAS_BASE) && (addr_i <= `PERI_ALIAS_LAST);
    assign base = in_peri ? `PERI_BAND_BASE : `SRAM_BAND_BASE;
    assign offs = addr_i - (in_peri ? `PERI_ALIAS_BASE : `SRAM_ALIAS_BASE);

    always_comb begin
        // RL3 fetches not remapped
        if (in_sram && !fetch_i)
            region_o = REG_SRAM;
        else if (in_peri && !fetch_i)
            region_o = REG_PERI;
        else
            region_o = REG_NONE;
    end

    // RL5 alias fetch forbidden
    assign fetch_fault_o = in_peri && fetch_i;

    // RL7 offset is byte*32 plus bit*4
    assign target_o = base + {12'h000, offs[`ALIAS_WORD_SHIFT +: `BAND_OFFSET_BITS]};
    // RL8 bit number 0 to 7
    assign bit_o = offs[`ALIAS_BIT_MSB:`ALIAS_BIT_LSB];
endmodule

/* File: hdl/bitband_defines.svh */
// Address map, alias field and access size constants for the bit-band remapper.
// Assumes a 32-bit byte-addressed bus with little-endian byte lanes.
`ifndef BITBAND_DEFINES_SVH
`define BITBAND_DEFINES_SVH

`define SRAM_BAND_BASE 32'h2000_0000
`define SRAM_BAND_LAST 32'h2000_FFFF
`define SRAM_ALIAS_BASE 32'h2200_0000
`define SRAM_ALIAS_LAST 32'h221F_FFFF
`define PERI_BAND_BASE 32'h4000_0000
`define PERI_BAND_LAST 32'h400F_FFFF
`define PERI_ALIAS_BASE 32'h4200_0000
`define PERI_ALIAS_LAST 32'h43FF_FFFF
`define ALIAS_WORD_SHIFT 5
`define ALIAS_BIT_LSB 2
`define ALIAS_BIT_MSB 4
`define BAND_OFFSET_BITS 20
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

`endif

/* File: hdl/bitband_pkg.sv */
// Types shared by the bit-band remapper files.
// Assumes bitband_defines.svh is on the include path.
package bitband_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PASS = 2'b01,
        ST_RD = 2'b10,
        ST_WR = 2'b11
    } state_t;

    typedef enum logic [1:0] {
        REG_NONE = 2'b00,
        REG_SRAM = 2'b01,
        REG_PERI = 2'b10
    } region_t;
endpackage

/* File: hdl/bitband_remap.sv */
// Bit-band alias remapper between the core data bus and memory bus.
// Assumes a simple valid/ready request bus on both sides and one clock.
// What this block does
// RL1: Bit-band regions are the low 64 KB of SRAM with a 2 MB alias and the low 1 MB of peripheral space with a 32 MB alias.
// RL2: Direct accesses to the SRAM bit-band range behave as plain SRAM accesses.
// RL3: Data accesses to the SRAM alias are remapped to bits; fetches there pass unremapped.
// RL4: Direct accesses to the peripheral bit-band range behave as plain peripheral accesses.
// RL5: Data accesses to the peripheral alias are remapped; fetches there are refused with an error.
// RL6: An alias write reads the target, changes one bit and writes back as one locked sequence.
// RL7: The alias offset is 32 times the byte offset plus 4 times the bit number.
// RL8: The bit number 0 to 7 comes from address bits 4 down to 2 of the alias word.
// RL9: The memory access keeps the width of the alias access.
// RL10: Bit 0 of written data sets or clears the targeted bit.
// RL11: Bits 31 to 1 of alias write data are ignored.
// RL12: An alias read returns zero or one according to the targeted bit.
// RL13: Byte lanes are little-endian, lowest address in the least significant byte.
// RL14: Accesses outside both alias ranges pass through unchanged.
`timescale 1ns/100ps
`include "bitband_defines.svh"

module bitband_remap (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [31:0] req_addr_i,
    input wire logic req_write_i,
    input wire logic req_fetch_i,
    input wire logic [1:0] req_size_i,
    input wire logic [31:0] req_wdata_i,
    output logic rsp_valid_o,
    output logic [31:0] rsp_rdata_o,
    output logic rsp_error_o,
    output logic mem_valid_o,
    input wire logic mem_ready_i,
    output logic [31:0] mem_addr_o,
    output logic mem_write_o,
    output logic [1:0] mem_size_o,
    output logic [31:0] mem_wdata_o,
    output logic mem_lock_o,
    input wire logic mem_rvalid_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_error_i
);
    import bitband_pkg::*;

    typedef struct packed {
        state_t st;
        logic write;
        logic [31:0] addr;
        logic [1:0] size;
        logic [31:0] wdata;
        logic [4:0] bitpos;
        logic wbit;
        logic issued;
        logic rsp_valid;
        logic [31:0] rdata;
        logic rsp_error;
    } regs_t;

    regs_t q_r;
    regs_t q_nxt;
    region_t region;
    logic fetch_fault;
    logic [31:0] target;
    logic [2:0] bitn;
    logic [4:0] lane_bit;
    logic [31:0] mask;
    logic [31:0] merged;

    ////////////////////////////////////////////////////////////////////////
    alias_decode i_alias_decode (
        .addr_i(req_addr_i),
        .fetch_i(req_fetch_i),
        .region_o(region),
        .fetch_fault_o(fetch_fault),
        .target_o(target),
        .bit_o(bitn)
    );

    // RL13 lane position little-endian
    assign lane_bit = {target[1:0], bitn};
    assign mask = 32'h0000_0001 << q_r.bitpos;
    // RL10 set or clear from bit 0
    assign merged = q_r.wbit ? (mem_rdata_i | mask) : (mem_rdata_i & ~mask);

    ////////////////////////////////////////////////////////////////////////
    assign req_ready_o = (q_r.st == ST_IDLE) && !q_r.rsp_valid;
    assign rsp_valid_o = q_r.rsp_valid;
    assign rsp_rdata_o = q_r.rdata;
    assign rsp_error_o = q_r.rsp_error;
    assign mem_valid_o = (q_r.st != ST_IDLE) && !q_r.issued;
    assign mem_addr_o = q_r.addr;
    // RL9 width kept
    assign mem_size_o = q_r.size;
    assign mem_write_o = (q_r.st == ST_WR) || ((q_r.st == ST_PASS) && q_r.write);
    assign mem_wdata_o = q_r.wdata;
    // RL6 bus held across the pair
    assign mem_lock_o = (q_r.st == ST_RD) || (q_r.st == ST_WR);

    always_comb begin
        q_nxt = q_r;
        q_nxt.rsp_valid = 1'b0;
        case (q_r.st)
            ST_IDLE: begin
                if (req_valid_i && req_ready_o) begin
                    q_nxt.write = req_write_i;
                    q_nxt.size = req_size_i;
                    q_nxt.issued = 1'b0;
                    q_nxt.rsp_error = 1'b0;
                    if (fetch_fault) begin
                        // RL5 alias fetch refused
                        q_nxt.rsp_valid = 1'b1;
                        q_nxt.rsp_error = 1'b1;
                        q_nxt.rdata = 32'h0000_0000;
                    end else if (region == REG_NONE) begin
                        // RL2 RL4 RL14 plain pass-through
                        q_nxt.st = ST_PASS;
                        q_nxt.addr = req_addr_i;
                        q_nxt.wdata = req_wdata_i;
                    end else begin
                        // RL1 RL7 remapped target
                        q_nxt.st = ST_RD;
                        q_nxt.addr = target;
                        q_nxt.bitpos = lane_bit;
                        // RL11 upper bits dropped
                        q_nxt.wbit = req_wdata_i[0];
                    end
                end
            end
            ST_PASS: begin
                if (mem_valid_o && mem_ready_i)
                    q_nxt.issued = 1'b1;
                if (mem_rvalid_i) begin
                    q_nxt.st = ST_IDLE;
                    q_nxt.rsp_valid = 1'b1;
                    q_nxt.rdata = mem_rdata_i;
                    q_nxt.rsp_error = mem_error_i;
                end
            end
            ST_RD: begin
                if (mem_valid_o && mem_ready_i)
                    q_nxt.issued = 1'b1;
                if (mem_rvalid_i) begin
                    q_nxt.issued = 1'b0;
                    if (mem_error_i || !q_r.write) begin
                        // RL12 zero-extended bit
                        q_nxt.st = ST_IDLE;
                        q_nxt.rsp_valid = 1'b1;
                        q_nxt.rsp_error = mem_error_i;
                        q_nxt.rdata = {31'h0000_0000, mem_rdata_i[q_r.bitpos]};
                    end else begin
                        // RL6 write back modified word
                        q_nxt.st = ST_WR;
                        q_nxt.wdata = merged;
                    end
                end
            end
            ST_WR: begin
                if (mem_valid_o && mem_ready_i)
                    q_nxt.issued = 1'b1;
                if (mem_rvalid_i) begin
                    q_nxt.st = ST_IDLE;
                    q_nxt.rsp_valid = 1'b1;
                    q_nxt.rsp_error = mem_error_i;
                    q_nxt.rdata = 32'h0000_0000;
                end
            end
            default: q_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i)
            q_r <= '0;
        else
            q_r <= q_nxt;
    end
endmodule

/* File: verification/bitband_remap_bench.sv */
// Bench for bitband_remap against mem_model.
// Assumes hdl/ on the include path.
`timescale 1ns/100ps
module bitband_remap_bench;
logic clk_i = 1'h0, resetn_i = 1'h0, vld = 1'h0, wr = 1'h0, fe = 1'h0, slow = 1'h0, er;
logic [1:0] sz = 2'h0, ls;
logic [31:0] ad = 32'h0, wd = 32'h0, rd, la;
int err_total = 0, n_checks = 0;
wire rdy, rv, re, mv, mr, mw;
wire [31:0] rdat, ma, mwd, mrd;
wire [1:0] ms;
always #5 clk_i = ~clk_i;
bitband_remap i_bitband_remap (.clk_i, .resetn_i, .req_valid_i(vld), .req_ready_o(rdy), .req_addr_i(ad),
    .req_write_i(wr), .req_fetch_i(fe), .req_size_i(sz), .req_wdata_i(wd), .rsp_valid_o(rv), .rsp_rdata_o(rdat),
    .rsp_error_o(re), .mem_valid_o(mv), .mem_ready_i(mr), .mem_addr_o(ma), .mem_write_o(mw), .mem_size_o(ms),
    .mem_wdata_o(mwd), .mem_lock_o(), .mem_rvalid_i(mr), .mem_rdata_i(mrd), .mem_error_i(1'h0));
mem_model i_mem_model (.clk_i, .slow_i(slow), .vld_i(mv), .wr_i(mw), .addr_i(ma), .wdata_i(mwd),
    .rdy_o(mr), .rdata_o(mrd));
always @(posedge clk_i) if (mv & mr) begin
    la <= ma;
    ls <= ms;
end
////////////////////////////////////////////////////////////
task automatic op(input [31:0] a, input [1:0] k, input [1:0] s, input [31:0] dv);
    int n;
    n = 0;
    while (rdy !== 1'h1) @(negedge clk_i);
    vld = 1'h1;
    ad = a;
    wr = k[0];
    fe = k[1];
    sz = s;
    wd = dv;
    @(negedge clk_i);
    vld = 1'h0;
    while (rv !== 1'h1 && n < 40) begin
        @(negedge clk_i);
        n++;
    end
    rd = rdat;
    er = re;
    if (n == 40) chk("rsp_valid", 32'h1, 32'h0);
endtask
task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e) begin
        err_total++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
    end
endtask
task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
////////////////////////////////////////////////////////////
task t_pass;
    op(32'h2000_0000, 2'h1, 2'h2, 32'h0);
    op(32'h2000_0004, 2'h1, 2'h2, 32'h1234_5678);
    op(32'h4000_0008, 2'h1, 2'h2, 32'hFFFF_FFFE);
    op(32'h2000_0004, 2'h0, 2'h2, 32'h0);
    chk("sram", 32'h1234_5678, rd);
    op(32'h4000_0008, 2'h0, 2'h2, 32'h0);
    chk("peri", 32'hFFFF_FFFE, rd);
    chk("addr", 32'h4000_0008, la);
    $display("t_pass done");
endtask
// Slow memory stretches both halves of the sequence
task t_awr;
    slow = 1'h1;
    op(32'h2200_001C, 2'h1, 2'h2, 32'h0000_00FF);
    op(32'h2200_002C, 2'h1, 2'h2, 32'h0000_0001);
    op(32'h2000_0000, 2'h0, 2'h2, 32'h0);
    chk("set", 32'h0000_0880, rd);
    op(32'h2200_001C, 2'h1, 2'h2, 32'h0000_000E);
    op(32'h2000_0000, 2'h0, 2'h2, 32'h0);
    chk("clear", 32'h0000_0800, rd);
    slow = 1'h0;
    $display("t_awr done");
endtask
task t_ard;
    op(32'h2200_002C, 2'h0, 2'h2, 32'h0);
    chk("bit_set", 32'h1, rd);
    op(32'h2200_0024, 2'h0, 2'h2, 32'h0);
    chk("bit_clr", 32'h0, rd);
    $display("t_ard done");
endtask
task t_peri;
    op(32'h4200_0100, 2'h1, 2'h0, 32'h1);
    chk("size", 32'h0, {30'h0, ls});
    op(32'h4000_0008, 2'h0, 2'h2, 32'h0);
    chk("peri_bit", 32'hFFFF_FFFF, rd);
    $display("t_peri done");
endtask
// Top of the peripheral band lands in the top byte lane
task t_edge;
    op(32'h400F_FFFC, 2'h1, 2'h2, 32'h0);
    op(32'h43FF_FFFC, 2'h1, 2'h0, 32'hFFFF_FFFF);
    chk("edge_target", 32'h400F_FFFF, la);
    op(32'h400F_FFFC, 2'h0, 2'h2, 32'h0);
    chk("edge_lane", 32'h8000_0000, rd);
    op(32'h43FF_FFFC, 2'h0, 2'h0, 32'h0);
    chk("edge_bit7", 32'h1, rd);
    $display("t_edge done");
endtask
task t_fetch;
    op(32'h4200_0000, 2'h2, 2'h2, 32'h0);
    chk("fetch_err", 32'h1, {31'h0, er});
    op(32'h2200_0000, 2'h2, 2'h2, 32'h0);
    chk("fetch_data", 32'h0000_0800, rd);
    $display("t_fetch done");
endtask
initial begin
    repeat (3) @(negedge clk_i);
    resetn_i = 1'h1;
    t_pass();
    t_awr();
    t_ard();
    t_peri();
    t_edge();
    t_fetch();
    final_report();
end
// About 20 ops of under 10 cycles each
initial begin
    #20000;
    chk("watchdog", 32'h1, 32'h0);
    final_report();
end
endmodule

/* File: verification/bitband_remap_chk.sv */
// Port checker for bitband_remap.
// Assumes one clock and a sync active-low reset.
`timescale 1ns/100ps
module bitband_remap_chk (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic [31:0] req_addr_i,
    input wire logic req_write_i,
    input wire logic req_fetch_i,
    input wire logic [1:0] req_size_i,
    input wire logic rsp_valid_o,
    input wire logic [31:0] rsp_rdata_o,
    input wire logic rsp_error_o,
    input wire logic mem_valid_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic mem_write_o,
    input wire logic [1:0] mem_size_o,
    input wire logic mem_lock_o,
    input wire logic mem_rvalid_i
);
default clocking @(posedge clk_i); endclocking
default disable iff (!resetn_i);
wire tk = req_valid_i & req_ready_o;
wire pa = req_addr_i[31:25] == 7'h21;
wire sa = req_addr_i[31:21] == 11'h110;
// Taken data access to either alias
wire al = tk & !req_fetch_i & (pa | sa);
////////////////////////////////////////////////////////////
property p_ferr; tk & req_fetch_i & pa |=> rsp_valid_o & rsp_error_o & !mem_valid_o; endproperty
a_ferr: assert property (p_ferr) else $error("alias fetch not refused");
property p_sfet; tk & req_fetch_i & sa |=> mem_valid_o && mem_addr_o == $past(req_addr_i); endproperty
a_sfet: assert property (p_sfet) else $error("sram alias fetch remapped");
property p_pass; tk & !pa & !sa |=> mem_addr_o == $past(req_addr_i) && mem_size_o == $past(req_size_i); endproperty
a_pass: assert property (p_pass) else $error("pass access altered");
property p_tgt; al |=> mem_valid_o && mem_addr_o == {$past(req_addr_i[31:28]), 8'h00, $past(req_addr_i[24:5])}; endproperty
a_tgt: assert property (p_tgt) else $error("alias target wrong");
property p_size; al |=> mem_lock_o && !mem_write_o && mem_size_o == $past(req_size_i); endproperty
a_size: assert property (p_size) else $error("alias width or read phase wrong");
property p_rmw; al & req_write_i |-> ##[2:8] mem_valid_o && mem_write_o && mem_lock_o; endproperty
a_rmw: assert property (p_rmw) else $error("no locked write-back");
property p_busy; mem_lock_o |-> !req_ready_o; endproperty
a_busy: assert property (p_busy) else $error("request taken inside locked sequence");
property p_rsp; mem_rvalid_i && !mem_lock_o |=> rsp_valid_o; endproperty
a_rsp: assert property (p_rsp) else $error("pass response late");
property p_bit; rsp_valid_o && !mem_lock_o && $past(mem_lock_o) && !$past(mem_write_o) |-> rsp_rdata_o[31:1] == 31'h0; endproperty
a_bit: assert property (p_bit) else $error("alias read not zero-extended");
c_lock: cover property (mem_lock_o && mem_write_o && mem_valid_o);
c_awr: cover property (al & req_write_i);
c_ard: cover property (al & !req_write_i);
c_fet: cover property (tk & req_fetch_i & pa);
endmodule
bind bitband_remap bitband_remap_chk i_bitband_remap_chk (.*);

/* File: verification/mem_model.sv */
// Memory model: 16 words, completes on acceptance.
// Slow mode accepts every other cycle, so waits are exercised.
`timescale 1ns/100ps
module mem_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic vld_i,
    input wire logic wr_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic rdy_o,
    output logic [31:0] rdata_o
);
logic [31:0] m [16];
logic d = 1'h0;
assign rdy_o = vld_i & (~slow_i | d);
// Idle data inverted, so stale values never pass
assign rdata_o = rdy_o ? m[addr_i[5:2]] : ~m[addr_i[5:2]];
always @(posedge clk_i) begin
    d <= vld_i & ~d;
    if (rdy_o & wr_i)
        m[addr_i[5:2]] <= wdata_i;
end
endmodule
